/* File: hdl/sac_pkg.sv */
// Overview of operation
// - Serial bits enter the shift register only while the frame strobe is low.
// - Each rising serial clock edge with the strobe low shifts the data input in.
// - A frame is a channel byte followed by an attenuation byte, sixteen bits in all.
// - Each byte travels most significant bit first, channel byte before code byte.
// - Only frames whose channel byte is zero are acted on; others change only the last channel byte and the discard count.
// - When the strobe returns high the shifted word is copied into the holding latch.
// - After each accepted frame the new code is decoded and the matching ladder tap, or mute, is driven.
// - At most one tap select is ever active, so two taps are never paralleled.
// - Codes 0 to 62 select that many decibels of attenuation, one per step.
// - After power-up the block is muted until a valid frame selects a level.
// - Any code of 63 or above selects mute instead of a tap.
// - A mute code is accepted at any time and applied two core cycles after the latch of its own frame.
package sac_pkg;

  localparam int          BYTE_BITS      = 8;
  localparam int          FRAME_BITS     = 2 * BYTE_BITS;
  localparam int          TAP_COUNT      = 63;
  localparam int          COUNT_W        = 8;
  localparam logic [7:0]  CHAN_SELF      = 8'h00;
  localparam logic [7:0]  MUTE_MIN_CODE  = 8'h3f;
  localparam logic [7:0]  CODE_RESET     = 8'hff;
  localparam logic        MUTE_RESET     = 1'b1;
  localparam int          CORE_PERIOD_NS = 100;
  localparam int          STROBE_LEAD_NS = 150;
  localparam int          STROBE_LEAD_CYC = (STROBE_LEAD_NS + CORE_PERIOD_NS - 1)
                                            / CORE_PERIOD_NS;

  typedef struct packed {
    logic [BYTE_BITS-1:0] channel_select_bits;
    logic [BYTE_BITS-1:0] attenuation_code_bits;
  } sac_frame_s;

  typedef enum logic [1:0] {
    UPD_IDLE  = 2'b00,
    UPD_CHECK = 2'b01
  } sac_upd_e;

  typedef logic [TAP_COUNT-1:0] sac_taps_t;

endpackage : sac_pkg

/* File: hdl/sac_tap_decode.sv */
module sac_tap_decode
  import sac_pkg::*;
(
  input  wire logic [7:0] code,
  output sac_taps_t       taps,
  output logic            mute
);

  // One comparator per tap; only the tap equal to the code can be set.
  for (genvar i = 0; i < TAP_COUNT; i++) begin : g_tap
    assign taps[i] = (code == 8'(i));
  end

  assign mute = (code >= MUTE_MIN_CODE);

endmodule : sac_tap_decode

/* File: hdl/sac_attn_ctrl.sv */
module sac_attn_ctrl
  import sac_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               RST_B,
  input  wire logic               LINK_CLK,
  input  wire logic               FRAME_STROBE_B,
  input  wire logic               SERIAL_DATA,
  output sac_taps_t               TAP_SEL,
  output logic                    MUTE,
  output logic [7:0]              ATTEN_CODE,
  output logic                    UPDATE_PULSE,
  output logic                    IGNORE_PULSE,
  output logic [7:0]              LAST_CHANNEL,
  output logic [COUNT_W-1:0]      ACCEPT_COUNT,
  output logic [COUNT_W-1:0]      IGNORE_COUNT
);

  // Link domain: the shift register runs on the serial clock itself.
  // It powers up cleared, since the link domain has no reset of its own.
  sac_frame_s          shift_q = '0;

  // Core domain state.
  logic                strobe_s1_q;
  logic                strobe_s2_q;
  logic                strobe_s3_q;
  logic                strobe_rise;
  sac_upd_e            upd_q;
  sac_upd_e            upd_d;
  sac_frame_s          hold_q;
  logic [7:0]          code_q;
  logic                update_q;
  logic                ignore_q;
  logic [7:0]          last_chan_q;
  logic [COUNT_W-1:0]  acc_cnt_q;
  logic [COUNT_W-1:0]  ign_cnt_q;
  sac_taps_t           taps_q;
  logic                mute_q;
  logic [7:0]          atten_q;
  sac_taps_t           dec_taps;
  logic                dec_mute;

  // Shifting is gated by the strobe; the newest bit enters at the bottom.
  always_ff @(posedge LINK_CLK) begin
    if (!FRAME_STROBE_B) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], SERIAL_DATA};
    end
  end

  // The strobe pin is brought into the core clock through three flip-flops.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      strobe_s1_q <= 1'b1;
      strobe_s2_q <= 1'b1;
      strobe_s3_q <= 1'b1;
    end else begin
      strobe_s1_q <= FRAME_STROBE_B;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end

  assign strobe_rise = strobe_s2_q & ~strobe_s3_q;

  // Update sequencer: latch on strobe rise, then check the channel byte.
  always_comb begin
    upd_d = upd_q;
    case (upd_q)
      UPD_IDLE: begin
        if (strobe_rise) begin
          upd_d = UPD_CHECK;
        end
      end
      UPD_CHECK: begin
        upd_d = UPD_IDLE;
      end
      default: begin
        upd_d = UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      upd_q <= UPD_IDLE;
    end else begin
      upd_q <= upd_d;
    end
  end

  // Shifting stops while the strobe is high, so the word is stable here.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      hold_q <= '0;
    end else if (upd_q == UPD_IDLE && strobe_rise) begin
      hold_q <= shift_q;
    end
  end

  // Accept or discard the latched frame according to its channel byte.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      code_q   <= CODE_RESET;
      update_q <= 1'b0;
      ignore_q <= 1'b0;
    end else if (upd_q == UPD_CHECK) begin
      if (hold_q.channel_select_bits == CHAN_SELF) begin
        code_q   <= hold_q.attenuation_code_bits;
        update_q <= 1'b1;
        ignore_q <= 1'b0;
      end else begin
        update_q <= 1'b0;
        ignore_q <= 1'b1;
      end
    end else begin
      update_q <= 1'b0;
      ignore_q <= 1'b0;
    end
  end

  // Channel byte of the most recent frame, whether accepted or not.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      last_chan_q <= CHAN_SELF;
    end else if (upd_q == UPD_CHECK) begin
      last_chan_q <= hold_q.channel_select_bits;
    end
  end

  // Wrapping counters of accepted and discarded frames.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      acc_cnt_q <= '0;
      ign_cnt_q <= '0;
    end else begin
      if (update_q) begin
        acc_cnt_q <= acc_cnt_q + COUNT_W'(1);
      end
      if (ignore_q) begin
        ign_cnt_q <= ign_cnt_q + COUNT_W'(1);
      end
    end
  end

  sac_tap_decode u_dec (
    .code (code_q),
    .taps (dec_taps),
    .mute (dec_mute)
  );

  // Ladder selection is refreshed from the held code every cycle.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      taps_q  <= '0;
      mute_q  <= MUTE_RESET;
      atten_q <= CODE_RESET;
    end else begin
      taps_q  <= dec_mute ? '0 : dec_taps;
      mute_q  <= dec_mute;
      atten_q <= code_q;
    end
  end

  assign TAP_SEL      = taps_q;
  assign MUTE         = mute_q;
  assign ATTEN_CODE   = atten_q;
  assign UPDATE_PULSE = update_q;
  assign IGNORE_PULSE = ignore_q;
  assign LAST_CHANNEL = last_chan_q;
  assign ACCEPT_COUNT = acc_cnt_q;
  assign IGNORE_COUNT = ign_cnt_q;

  // Checks on the serial side.
  a_shift_in_bit: assert property (
    @(posedge LINK_CLK) disable iff (FRAME_STROBE_B)
    1'b1 |=> shift_q == {$past(shift_q[FRAME_BITS-2:0]), $past(SERIAL_DATA)})
    else $error("Shift register did not take the serial bit.");

  a_shift_gated: assert property (
    @(posedge LINK_CLK) disable iff (!FRAME_STROBE_B)
    1'b1 |=> $stable(shift_q))
    else $error("Shift register moved while the strobe was high.");

  a_shift_newest: assert property (
    @(posedge LINK_CLK) disable iff (FRAME_STROBE_B)
    1'b1 |=> shift_q[0] == $past(SERIAL_DATA))
    else $error("Newest shifted bit does not match the data input.");

  // Checks on the core side.
  a_mute_at_reset: assert property (
    @(posedge CORE_CLK)
    !RST_B |=> (mute_q && taps_q == '0 && code_q == CODE_RESET))
    else $error("Block is not muted after reset.");

  a_latch_word: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_IDLE && strobe_rise) |=> hold_q == $past(shift_q))
    else $error("Holding latch missed the shifted word.");

  a_chan_ignored: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_CHECK && hold_q.channel_select_bits != CHAN_SELF)
      |=> ($stable(code_q) && ignore_q && !update_q) ##1 $stable(taps_q))
    else $error("Frame for another channel changed the setting.");

  a_update_path: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_CHECK && hold_q.channel_select_bits == CHAN_SELF)
      |=> update_q ##1 (atten_q == $past(hold_q.attenuation_code_bits, 2)))
    else $error("Accepted code did not reach the ladder in two cycles.");

  a_taps_onehot: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    mute_q ? (taps_q == '0) : $onehot(taps_q))
    else $error("Ladder selection is not one-hot.");

  a_tap_matches: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (code_q < MUTE_MIN_CODE) |=> (!mute_q && taps_q[$past(code_q[5:0])]))
    else $error("Selected tap does not equal the code.");

  a_mute_codes: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (code_q >= MUTE_MIN_CODE) |=> mute_q)
    else $error("High code did not select mute.");

  a_code_holds: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_IDLE) |=> $stable(code_q))
    else $error("Code changed without a latched frame.");

  a_rise_to_check: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(strobe_s2_q) && upd_q == UPD_IDLE |=> upd_q == UPD_CHECK ##1 upd_q == UPD_IDLE)
    else $error("Update sequence did not follow the strobe rise.");

  a_reset_status: assert property (
    @(posedge CORE_CLK)
    !RST_B |=> (acc_cnt_q == '0 && ign_cnt_q == '0 && !update_q && !ignore_q
      && last_chan_q == CHAN_SELF))
    else $error("Status outputs are not cleared after reset.");

  a_reset_idle: assert property (
    @(posedge CORE_CLK)
    !RST_B |=> (upd_q == UPD_IDLE && strobe_s2_q && strobe_s3_q))
    else $error("Update sequencer is not idle after reset.");

  a_sync_chain: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    1'b1 |=> strobe_s3_q == $past(strobe_s2_q))
    else $error("Strobe edge detector lost a stage.");

  a_pulse_exclusive: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    !(update_q && ignore_q))
    else $error("Accept and discard pulses are high together.");

  a_update_single: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    update_q |=> !update_q)
    else $error("Accept pulse lasted more than one cycle.");

  a_ignore_single: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    ignore_q |=> !ignore_q)
    else $error("Discard pulse lasted more than one cycle.");

  a_accept_count: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    update_q |=> acc_cnt_q == $past(acc_cnt_q) + COUNT_W'(1))
    else $error("Accepted frame count did not step.");

  a_ignore_count: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    ignore_q |=> ign_cnt_q == $past(ign_cnt_q) + COUNT_W'(1))
    else $error("Discarded frame count did not step.");

  a_accept_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    !update_q |=> $stable(acc_cnt_q))
    else $error("Accepted frame count moved without a frame.");

  a_ignore_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    !ignore_q |=> $stable(ign_cnt_q))
    else $error("Discarded frame count moved without a frame.");

  a_last_channel: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_CHECK) |=> last_chan_q == $past(hold_q.channel_select_bits))
    else $error("Last channel byte was not recorded.");

  a_accept_code: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_CHECK && hold_q.channel_select_bits == CHAN_SELF)
      |=> code_q == $past(hold_q.attenuation_code_bits))
    else $error("Accepted code was not taken over.");

  a_check_once: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_CHECK) |=> upd_q == UPD_IDLE)
    else $error("Channel check lasted more than one cycle.");

  a_idle_waits: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    (upd_q == UPD_IDLE && !strobe_rise) |=> upd_q == UPD_IDLE)
    else $error("Update sequence started without a strobe rise.");

  a_hold_stable: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    !(upd_q == UPD_IDLE && strobe_rise) |=> $stable(hold_q))
    else $error("Holding latch changed without a strobe rise.");

  a_atten_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    1'b1 |=> atten_q == $past(code_q))
    else $error("Applied code does not follow the held code.");

  a_mute_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    1'b1 |=> mute_q == ($past(code_q) >= MUTE_MIN_CODE))
    else $error("Mute does not match the held code.");

  a_taps_steady: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    $stable(code_q) |=> $stable(taps_q))
    else $error("Ladder selection moved while the code held.");

  a_ignore_keeps_setting: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    ignore_q |-> ($stable(mute_q) && $stable(taps_q) && $stable(atten_q)))
    else $error("Discarded frame disturbed the ladder setting.");

  c_accept: cover property (
    @(posedge CORE_CLK) disable iff (!RST_B) update_q);

  c_ignore: cover property (
    @(posedge CORE_CLK) disable iff (!RST_B) ignore_q);

  c_mute_cmd: cover property (
    @(posedge CORE_CLK) disable iff (!RST_B) !mute_q ##1 mute_q);

  c_full_atten: cover property (
    @(posedge CORE_CLK) disable iff (!RST_B) taps_q[TAP_COUNT-1]);

  c_unmute: cover property (
    @(posedge CORE_CLK) disable iff (!RST_B) mute_q ##1 !mute_q);

endmodule : sac_attn_ctrl

/* File: tb/sac_host_model.sv */
module sac_host_model (
  output logic LINK_CLK,
  output logic FRAME_STROBE_B,
  output logic SERIAL_DATA
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    LINK_CLK       = 1'b0;
    FRAME_STROBE_B = 1'b1;
    SERIAL_DATA    = 1'b0;
  end

  // Sends the low n bits of w, most significant first; the link clock idles low.
  task automatic send(input logic [15:0] w, input int n, input logic framed);
    int i;
    #633;
    if (framed) FRAME_STROBE_B = 1'b0;
    #150;
    for (i = n - 1; i >= 0; i--) begin
      SERIAL_DATA = w[i];
      #7.5 LINK_CLK = 1'b1;
      #7.5 LINK_CLK = 1'b0;
    end
    FRAME_STROBE_B = 1'b1;
    SERIAL_DATA    = ~SERIAL_DATA;
  endtask : send
endmodule : sac_host_model

/* File: tb/testbench.sv */
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module testbench
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic             CORE_CLK = 1'b0;
  logic             RST_B    = 1'b0;
  logic             LINK_CLK;
  logic             FRAME_STROBE_B;
  logic             SERIAL_DATA;
  sac_taps_t        TAP_SEL;
  logic             MUTE;
  logic [7:0]       ATTEN_CODE;
  logic             UPDATE_PULSE;
  logic             IGNORE_PULSE;
  logic [7:0]       LAST_CHANNEL;
  logic [COUNT_W-1:0] ACCEPT_COUNT;
  logic [COUNT_W-1:0] IGNORE_COUNT;
  int               mismatches = 0;
  int               n_tests    = 0;
  int               cycles     = 0;
  logic [7:0]       exp_code   = 8'hff;
  logic [7:0]       n_acc      = 8'h00;
  logic [7:0]       n_ign      = 8'h00;

  sac_host_model i_sac_host_model (
    .LINK_CLK       (LINK_CLK),
    .FRAME_STROBE_B (FRAME_STROBE_B),
    .SERIAL_DATA    (SERIAL_DATA)
  );

  sac_attn_ctrl i_sac_attn_ctrl (
    .CORE_CLK       (CORE_CLK),
    .RST_B          (RST_B),
    .LINK_CLK       (LINK_CLK),
    .FRAME_STROBE_B (FRAME_STROBE_B),
    .SERIAL_DATA    (SERIAL_DATA),
    .TAP_SEL        (TAP_SEL),
    .MUTE           (MUTE),
    .ATTEN_CODE     (ATTEN_CODE),
    .UPDATE_PULSE   (UPDATE_PULSE),
    .IGNORE_PULSE   (IGNORE_PULSE),
    .LAST_CHANNEL   (LAST_CHANNEL),
    .ACCEPT_COUNT   (ACCEPT_COUNT),
    .IGNORE_COUNT   (IGNORE_COUNT)
  );

  initial begin
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  // Sends one frame and checks which status pulse answers it.
  task automatic push(input logic [15:0] w, input int n, input logic acc);
    int k;
    i_sac_host_model.send(w, n, 1'b1);
    for (k = 0; k < 12; k++) begin
      @(posedge CORE_CLK);
      #1;
      if (UPDATE_PULSE === 1'b1 || IGNORE_PULSE === 1'b1) break;
    end
    `CHK(UPDATE_PULSE, acc)
    `CHK(IGNORE_PULSE, ~acc)
    if (acc) n_acc++;
    else n_ign++;
    @(posedge CORE_CLK);
    #1;
  endtask : push

  task automatic check_setting();
    sac_taps_t e;
    e = '0;
    if (exp_code < MUTE_MIN_CODE) e[exp_code] = 1'b1;
    `CHK(ATTEN_CODE, exp_code)
    `CHK(MUTE, exp_code >= MUTE_MIN_CODE)
    `CHK(TAP_SEL, e)
    `CHK(ACCEPT_COUNT, n_acc)
    `CHK(IGNORE_COUNT, n_ign)
  endtask : check_setting

  task automatic t_codes();
    logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h1e, 8'h3e, 8'h3f, 8'h2a, 8'h40, 8'hff};
    foreach (codes[i]) begin
      push({CHAN_SELF, codes[i]}, 16, 1'b1);
      exp_code = codes[i];
      check_setting();
    end
  endtask : t_codes

  task automatic t_foreign();
    push({8'h01, 8'h05}, 16, 1'b0);
    check_setting();
    `CHK(LAST_CHANNEL, 8'h01)
    push({8'h80, 8'h00}, 16, 1'b0);
    check_setting();
  endtask : t_foreign

  task automatic t_strobe_high();
    push(16'h0000, 16, 1'b1);
    exp_code = 8'h00;
    i_sac_host_model.send(16'h00ff, 8, 1'b0);
    push(16'h000c, 8, 1'b1);
    exp_code = 8'h0c;
    check_setting();
  endtask : t_strobe_high

  task automatic t_ramp();
    logic [7:0] c;
    for (c = 8'h0d; c <= 8'h10; c++) begin
      push({CHAN_SELF, c}, 16, 1'b1);
      exp_code = c;
      check_setting();
    end
  endtask : t_ramp

  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    @(posedge CORE_CLK);
    #1;
    check_setting();
    t_codes();
    t_foreign();
    t_strobe_high();
    t_ramp();
    print_verdict();
  end
endmodule : testbench
